/* File: logic/ocd_regs.svh */
// Constants for the opcode decode fragment: opcodes, cycle counts, flag positions.
// Assumes inclusion by the decoder; holds definitions only.
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OCD_OP_CHK_DIR   8'h3d
`define OCD_OP_CHK_ACC   8'h4d
`define OCD_OP_CHK_IDX   8'h5d
`define OCD_OP_CHK_SHORT 8'h6d
`define OCD_OP_CHK_PLAIN 8'h7d
`define OCD_OP_COPY      8'h9f
`define OCD_OP_WAIT      8'h8f
// Opcode groups for operand-layout decode (upper nibble)
`define OCD_HI_BITTEST   4'h0
`define OCD_HI_FULL      4'hc
`define OCD_HI_LONG      4'hd
`define OCD_HI_SHORT     4'he

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define OCD_CYC_CHK_DIR  4'h4
`define OCD_CYC_CHK_REG  4'h3
`define OCD_CYC_CHK_SHORT 4'h5
`define OCD_CYC_CHK_PLAIN 4'h4
`define OCD_CYC_IMPLIED  4'h2
`define OCD_CYC_DEFAULT  4'h2

// ----------------------------------------
// Condition flag bit positions and reset values
// ----------------------------------------
`define OCD_FLAG_C       0
`define OCD_FLAG_Z       1
`define OCD_FLAG_N       2
`define OCD_FLAG_I       3
`define OCD_FLAG_H       4
`define OCD_FLAGS_RESET  5'h08
`define OCD_PC_RESET     16'h0000

`endif

/* File: logic/ocd_pkg.sv */
// Types shared by the opcode decode fragment.
// Assumes ocd_regs.svh sits beside it.
package ocd_pkg;

  // ----------------------------------------
  // Decoder states
  // ----------------------------------------
  typedef enum logic [2:0] {
    OCD_FETCH,
    OCD_OPND1,
    OCD_OPND2,
    OCD_EXEC,
    OCD_WAITING
  } ocd_state_e;

  // Operand layouts
  typedef enum logic [2:0] {
    OCD_L_NONE,
    OCD_L_DIR,
    OCD_L_SHORT,
    OCD_L_LONG,
    OCD_L_FULL,
    OCD_L_BITREL
  } ocd_layout_e;

  typedef struct packed {
    ocd_state_e  state;
    ocd_layout_e layout;
    logic [7:0]  opcode;
    logic [7:0]  opnd1;
    logic [7:0]  opnd2;
    logic [3:0]  cyc;
    logic [3:0]  cyc_total;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [4:0]  flags;
    logic [15:0] ea;
    logic        ea_valid;
    logic        done;
    logic        clk_halt;
  } ocd_state_s;

endpackage

/* File: logic/ocd_decoder.sv */
// Opcode decode and execute fragment: check, copy, wait and operand layouts.
// Assumes program memory answers fetch_addr with fetch_data in the same cycle,
// and that data reads for the check instruction return mem_data likewise.
//
// How it works
// - Check subtracts zero, sets N/Z, keeps H/C
// - 9F copies index to acc, flags untouched
// - 8F clears mask, halts clock until interrupt
// - Long offset: high then low, plus index
// - Full address: high byte then low byte
// - Short offset: one unsigned byte plus index
// - Bit test: direct address then branch offset
`include "ocd_regs.svh"

module ocd_decoder (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Program memory
  output      logic [15:0] fetch_addr,
  input  wire logic [7:0]  fetch_data,
  // Operand data read
  output      logic [15:0] mem_addr,
  output      logic        mem_read,
  input  wire logic [7:0]  mem_data,
  // Interrupt wake-up
  input  wire logic        irq_pending,
  // Core state seen by the rest of the CPU
  output      logic [7:0]  acc,
  output      logic [7:0]  idx,
  output      logic [4:0]  condition_flags,
  output      logic [15:0] pc,
  output      logic [15:0] operand_addr,
  output      logic [7:0]  branch_offset,
  output      logic        operand_addr_valid,
  output      logic        cpu_clk_halt,
  output      logic        instr_done
);

  ocd_pkg::ocd_state_s r;
  ocd_pkg::ocd_state_s next_r;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic ocd_pkg::ocd_layout_e layout_of(input logic [7:0] op);
    ocd_pkg::ocd_layout_e l;
    l = ocd_pkg::OCD_L_NONE;
    case (op[7:4])
      `OCD_HI_BITTEST: l = ocd_pkg::OCD_L_BITREL;
      `OCD_HI_FULL:    l = ocd_pkg::OCD_L_FULL;
      `OCD_HI_LONG:    l = ocd_pkg::OCD_L_LONG;
      default: begin
        if (op == `OCD_OP_CHK_DIR) begin
          l = ocd_pkg::OCD_L_DIR;
        end else if (op == `OCD_OP_CHK_SHORT || op[7:4] == `OCD_HI_SHORT) begin
          l = ocd_pkg::OCD_L_SHORT;
        end
      end
    endcase
    return l;
  endfunction

  function automatic logic [3:0] cycles_of(input logic [7:0] op);
    logic [3:0] c;
    c = `OCD_CYC_DEFAULT;
    case (op)
      `OCD_OP_CHK_DIR: c = `OCD_CYC_CHK_DIR;
      `OCD_OP_CHK_ACC: c = `OCD_CYC_CHK_REG;
      `OCD_OP_CHK_IDX: c = `OCD_CYC_CHK_REG;
      `OCD_OP_CHK_SHORT: c = `OCD_CYC_CHK_SHORT;
      `OCD_OP_CHK_PLAIN: c = `OCD_CYC_CHK_PLAIN;
      `OCD_OP_COPY:    c = `OCD_CYC_IMPLIED;
      `OCD_OP_WAIT:    c = `OCD_CYC_IMPLIED;
      default:         c = `OCD_CYC_DEFAULT;
    endcase
    return c;
  endfunction

  // N and Z from a value minus zero
  function automatic logic [4:0] nz_flags(input logic [4:0] f, input logic [7:0] v);
    logic [4:0] o;
    o = f;
    o[`OCD_FLAG_N] = v[7];
    o[`OCD_FLAG_Z] = (v == 8'h00);
    return o;
  endfunction

  function automatic logic is_check_mem(input logic [7:0] op);
    return op == `OCD_OP_CHK_DIR || op == `OCD_OP_CHK_SHORT || op == `OCD_OP_CHK_PLAIN;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.state)
      ocd_pkg::OCD_FETCH: begin
        next_r.opcode    = fetch_data;
        next_r.layout    = layout_of(fetch_data);
        next_r.cyc_total = cycles_of(fetch_data);
        next_r.cyc       = 4'h1;
        next_r.ea_valid  = 1'b0;
        next_r.pc        = r.pc + 16'h0001;
        if (layout_of(fetch_data) == ocd_pkg::OCD_L_NONE) begin
          next_r.state = ocd_pkg::OCD_EXEC;
        end else begin
          next_r.state = ocd_pkg::OCD_OPND1;
        end
      end
      ocd_pkg::OCD_OPND1: begin
        next_r.opnd1 = fetch_data;
        next_r.pc    = r.pc + 16'h0001;
        next_r.cyc   = r.cyc + 4'h1;
        case (r.layout)
          ocd_pkg::OCD_L_DIR: begin
            next_r.ea       = {8'h00, fetch_data};
            next_r.ea_valid = 1'b1;
            next_r.state    = ocd_pkg::OCD_EXEC;
          end
          ocd_pkg::OCD_L_SHORT: begin
            next_r.ea       = {8'h00, fetch_data} + {8'h00, r.idx};
            next_r.ea_valid = 1'b1;
            next_r.state    = ocd_pkg::OCD_EXEC;
          end
          default: begin
            next_r.state = ocd_pkg::OCD_OPND2;
          end
        endcase
      end
      ocd_pkg::OCD_OPND2: begin
        next_r.opnd2    = fetch_data;
        next_r.pc       = r.pc + 16'h0001;
        next_r.cyc      = r.cyc + 4'h1;
        next_r.ea_valid = 1'b1;
        next_r.state    = ocd_pkg::OCD_EXEC;
        case (r.layout)
          ocd_pkg::OCD_L_LONG:   next_r.ea = {r.opnd1, fetch_data} + {8'h00, r.idx};
          ocd_pkg::OCD_L_FULL:   next_r.ea = {r.opnd1, fetch_data};
          ocd_pkg::OCD_L_BITREL: next_r.ea = {8'h00, r.opnd1};
          default:               next_r.ea = r.ea;
        endcase
      end
      ocd_pkg::OCD_EXEC: begin
        // Pad to the listed count so outside timing stays cycle-true
        if (r.cyc + 4'h1 >= r.cyc_total) begin
          next_r.done  = 1'b1;
          next_r.state = ocd_pkg::OCD_FETCH;
          case (r.opcode)
            `OCD_OP_CHK_ACC: next_r.flags = nz_flags(r.flags, r.acc);
            `OCD_OP_CHK_IDX: next_r.flags = nz_flags(r.flags, r.idx);
            `OCD_OP_CHK_DIR,
            `OCD_OP_CHK_SHORT: next_r.flags = nz_flags(r.flags, mem_data);
            `OCD_OP_CHK_PLAIN: next_r.flags = nz_flags(r.flags, mem_data);
            `OCD_OP_COPY:    next_r.acc   = r.idx;
            `OCD_OP_WAIT: begin
              next_r.flags[`OCD_FLAG_I] = 1'b0;
              next_r.clk_halt           = 1'b1;
              next_r.state              = ocd_pkg::OCD_WAITING;
            end
            default: next_r.flags = r.flags;
          endcase
        end else begin
          next_r.cyc = r.cyc + 4'h1;
          if (r.opcode == `OCD_OP_CHK_PLAIN) begin
            next_r.ea       = {8'h00, r.idx};
            next_r.ea_valid = 1'b1;
          end
        end
      end
      ocd_pkg::OCD_WAITING: begin
        // Only an interrupt restarts the core; the vector fetch is elsewhere
        if (irq_pending) begin
          next_r.clk_halt = 1'b0;
          next_r.state    = ocd_pkg::OCD_FETCH;
        end
      end
      default: begin
        next_r.state = ocd_pkg::OCD_FETCH;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r           <= '0;
      r.state     <= ocd_pkg::OCD_FETCH;
      r.layout    <= ocd_pkg::OCD_L_NONE;
      r.pc        <= `OCD_PC_RESET;
      r.flags     <= `OCD_FLAGS_RESET;
      r.cyc_total <= `OCD_CYC_DEFAULT;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fetch_addr         = r.pc;
  assign mem_addr           = r.ea;
  assign mem_read           = r.state == ocd_pkg::OCD_EXEC && r.ea_valid && is_check_mem(r.opcode);
  assign acc                = r.acc;
  assign idx                = r.idx;
  assign condition_flags    = r.flags;
  assign pc                 = r.pc;
  assign operand_addr       = r.ea;
  assign branch_offset      = r.opnd2;
  assign operand_addr_valid = r.ea_valid;
  assign cpu_clk_halt       = r.clk_halt;
  assign instr_done         = r.done;

endmodule

/* File: verif/ocd_decoder_props.sv */
// Checker for the opcode decode fragment, bound to ocd_decoder.
// Assumes one sys_clk domain and a one-cycle instr_done pulse.
module ocd_decoder_props (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Program memory
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0]  fetch_data,
  // Operand data read
  input wire logic [15:0] mem_addr,
  input wire logic        mem_read,
  input wire logic [7:0]  mem_data,
  // Interrupt wake-up
  input wire logic        irq_pending,
  // Core state
  input wire logic [7:0]  acc,
  input wire logic [7:0]  idx,
  input wire logic [4:0]  condition_flags,
  input wire logic [15:0] pc,
  input wire logic [15:0] operand_addr,
  input wire logic [7:0]  branch_offset,
  input wire logic        operand_addr_valid,
  input wire logic        cpu_clk_halt,
  input wire logic        instr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       first;
  logic       fe;
  logic [7:0] op;
  // Opcode edges only; the wake-up fetch is left unchecked
  assign fe = first || (instr_done && !cpu_clk_halt);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first <= 1'b1;
      op    <= 8'h00;
    end else begin
      first <= 1'b0;
      op    <= fe ? fetch_data : op;
    end
  end
  property p_chk4;
    fe && (fetch_data == 8'h3d || fetch_data == 8'h7d) |=> !instr_done [*3] ##1 instr_done;
  endproperty
  a_chk4: assert property (p_chk4) else $error("check form length wrong");
  property p_chk5;
    fe && fetch_data == 8'h6d |=> !instr_done [*4] ##1 instr_done;
  endproperty
  a_chk5: assert property (p_chk5) else $error("offset check length wrong");
  property p_chk_mem;
    instr_done && (op == 8'h3d || op == 8'h6d || op == 8'h7d) |-> $past(mem_read) &&
      condition_flags[2] == $past(mem_data[7]) && condition_flags[1] == ($past(mem_data) == 8'h00);
  endproperty
  a_chk_mem: assert property (p_chk_mem) else $error("memory check flags wrong");
  property p_chk_acc;
    instr_done && op == 8'h4d |-> condition_flags[2] == acc[7] && condition_flags[1] == (acc == 8'h00);
  endproperty
  a_chk_acc: assert property (p_chk_acc) else $error("acc check flags wrong");
  property p_copy;
    fe && fetch_data == 8'h9f |-> ##2 instr_done && acc == idx &&
      condition_flags == $past(condition_flags, 2) && pc == $past(pc, 2) + 16'h0001;
  endproperty
  a_copy: assert property (p_copy) else $error("copy wrong");
  property p_wait;
    fe && fetch_data == 8'h8f |-> ##2 instr_done && cpu_clk_halt && !condition_flags[3];
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");
  property p_halt;
    cpu_clk_halt && !irq_pending |=> cpu_clk_halt && $stable(fetch_addr);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not held");
  property p_short_off;
    fe && (fetch_data == 8'h6d || fetch_data[7:4] == 4'he) |-> ##2 operand_addr_valid &&
      operand_addr == 16'(idx) + {8'h00, $past(fetch_data)};
  endproperty
  a_short_off: assert property (p_short_off) else $error("short offset address wrong");
  property p_long_off;
    fe && fetch_data[7:4] == 4'hd |-> ##3
      operand_addr == {$past(fetch_data, 2), $past(fetch_data)} + 16'(idx);
  endproperty
  a_long_off: assert property (p_long_off) else $error("long offset address wrong");
  property p_full_addr;
    fe && fetch_data[7:4] == 4'hc |-> ##3 pc == $past(pc, 3) + 16'h0003 &&
      operand_addr == {$past(fetch_data, 2), $past(fetch_data)};
  endproperty
  a_full_addr: assert property (p_full_addr) else $error("full address wrong");
  property p_bit;
    fe && fetch_data[7:4] == 4'h0 |-> ##3 branch_offset == $past(fetch_data) &&
      operand_addr == {8'h00, $past(fetch_data, 2)};
  endproperty
  a_bit: assert property (p_bit) else $error("bit test operands wrong");
  c_chk: cover property (fe && fetch_data == 8'h6d);
  c_wait: cover property (cpu_clk_halt && irq_pending);
  c_full_addr: cover property (fe && fetch_data[7:4] == 4'hc);
endmodule
bind ocd_decoder ocd_decoder_props chk (
  .sys_clk            (sys_clk),
  .rst                (rst),
  .fetch_addr         (fetch_addr),
  .fetch_data         (fetch_data),
  .mem_addr           (mem_addr),
  .mem_read           (mem_read),
  .mem_data           (mem_data),
  .irq_pending        (irq_pending),
  .acc                (acc),
  .idx                (idx),
  .condition_flags    (condition_flags),
  .pc                 (pc),
  .operand_addr       (operand_addr),
  .branch_offset      (branch_offset),
  .operand_addr_valid (operand_addr_valid),
  .cpu_clk_halt       (cpu_clk_halt),
  .instr_done         (instr_done)
);

/* File: verif/ocd_prog_mem.sv */
// Program memory model answering both ports in the same cycle.
// Assumes the bench fills bytes before reset ends.
module ocd_prog_mem (
  // Fetch port
  input  wire logic [15:0] fetch_addr,
  output      logic [7:0]  fetch_data,
  // Operand port
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_read,
  output      logic [7:0]  mem_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bytes [0:255];
  // Unread data shows the inverse so a stale value cannot pass
  always_comb begin
    fetch_data = bytes[fetch_addr[7:0]];
    mem_data   = mem_read ? bytes[mem_addr[7:0]] : ~bytes[mem_addr[7:0]];
  end
endmodule

/* File: verif/test_cpu_opcode_decode_fragment.sv */
// Bench for the opcode decode fragment with a program memory model.
// Assumes acc and idx stay at zero since no load path exists here.
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_cpu_opcode_decode_fragment;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, irq_pending, mem_read, operand_addr_valid, cpu_clk_halt, instr_done;
  logic [15:0] fetch_addr, mem_addr, pc, operand_addr;
  logic [7:0]  fetch_data, mem_data, acc, idx, branch_offset;
  logic [4:0]  condition_flags;
  int          mismatches = 0;
  int          checks = 0;
  logic [7:0]  prog [0:20] = '{8'h9f, 8'h3d, 8'h80, 8'h4d, 8'h5d, 8'h6d, 8'h40, 8'h7d,
    8'hc7, 8'h12, 8'h34, 8'hd7, 8'h01, 8'h02, 8'he7, 8'h05, 8'h00, 8'h60, 8'hfe, 8'h8f, 8'h4d};
  ocd_decoder DUT (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .fetch_addr         (fetch_addr),
    .fetch_data         (fetch_data),
    .mem_addr           (mem_addr),
    .mem_read           (mem_read),
    .mem_data           (mem_data),
    .irq_pending        (irq_pending),
    .acc                (acc),
    .idx                (idx),
    .condition_flags    (condition_flags),
    .pc                 (pc),
    .operand_addr       (operand_addr),
    .branch_offset      (branch_offset),
    .operand_addr_valid (operand_addr_valid),
    .cpu_clk_halt       (cpu_clk_halt),
    .instr_done         (instr_done)
  );
  ocd_prog_mem mem (
    .fetch_addr (fetch_addr),
    .fetch_data (fetch_data),
    .mem_addr   (mem_addr),
    .mem_read   (mem_read),
    .mem_data   (mem_data)
  );
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Counts to the next done pulse; n of zero skips the length check
  task automatic run(input int n, input logic [4:0] f, input logic [15:0] p);
    int c;
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (instr_done !== 1'b1 && c < 40);
    `CHK("done", 1'b1, instr_done)
    if (n > 0) `CHK("cycles", n, c)
    `CHK("flags", f, condition_flags)
    `CHK("pc", p, pc)
  endtask
  task automatic t_check();
    run(0, 5'h08, 16'h0001);
    `CHK("acc", 8'h00, acc)
    run(4, 5'h0c, 16'h0003);
    run(3, 5'h0a, 16'h0004);
    run(3, 5'h0a, 16'h0005);
    run(5, 5'h0a, 16'h0007);
    `CHK("short_off", 16'h0040, operand_addr)
    run(4, 5'h0c, 16'h0008);
    $display("t_check done");
  endtask
  task automatic t_layout();
    run(0, 5'h0c, 16'h000b);
    `CHK("full_addr", 16'h1234, operand_addr)
    run(0, 5'h0c, 16'h000e);
    `CHK("long_off", 16'h0102, operand_addr)
    run(0, 5'h0c, 16'h0010);
    `CHK("short_off", 16'h0005, operand_addr)
    run(0, 5'h0c, 16'h0013);
    `CHK("dir", 16'h0060, operand_addr)
    `CHK("rel", 8'hfe, branch_offset)
    $display("t_layout done");
  endtask
  task automatic t_wait();
    run(2, 5'h04, 16'h0014);
    repeat (5) @(negedge sys_clk);
    `CHK("halt", 1'b1, cpu_clk_halt)
    `CHK("fetch", 16'h0014, fetch_addr)
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    run(0, 5'h02, 16'h0015);
    `CHK("wake", 1'b0, cpu_clk_halt)
    @(posedge sys_clk);
    irq_pending <= 1'b0;
    $display("t_wait done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #5000;
    mismatches++;
    results();
  end
  initial begin
    rst = 1'b1;
    irq_pending = 1'b0;
    for (int i = 0; i < 256; i++) mem.bytes[i] = (i < 21) ? prog[i] : 8'h00;
    mem.bytes[8'h80] = 8'h81;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_check();
    t_layout();
    t_wait();
    results();
  end
endmodule
